// [src/timer8_pkg.sv]
package timer8_pkg;

  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W   = 14;
  localparam int unsigned DATA_W   = 8;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_COUNTER      = 12'hfba;
  localparam logic [11:0] IDX_PERIOD       = 12'hfbb;
  localparam logic [11:0] IDX_CONTROL      = 12'hfbc;
  localparam logic [11:0] IDX_LIMIT        = 12'hfbd;
  localparam logic [11:0] IDX_CLOCK_SELECT = 12'hfbe;
  localparam logic [11:0] IDX_RESET_SELECT = 12'hfbf;

  localparam logic [1:0]  WORD_PAD         = 2'h0;

  localparam logic [ADDR_W-1:0] ADDR_COUNTER      = {IDX_COUNTER, WORD_PAD};
  localparam logic [ADDR_W-1:0] ADDR_PERIOD       = {IDX_PERIOD, WORD_PAD};
  localparam logic [ADDR_W-1:0] ADDR_CONTROL      = {IDX_CONTROL, WORD_PAD};
  localparam logic [ADDR_W-1:0] ADDR_LIMIT        = {IDX_LIMIT, WORD_PAD};
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_SELECT = {IDX_CLOCK_SELECT, WORD_PAD};
  localparam logic [ADDR_W-1:0] ADDR_RESET_SELECT = {IDX_RESET_SELECT, WORD_PAD};

  // ---------------------------------------------------------------
  // reset values and field widths
  // ---------------------------------------------------------------
  localparam logic [7:0]  COUNTER_RST  = 8'h00;
  localparam logic [7:0]  PERIOD_RST   = 8'hff;
  localparam logic [7:0]  CONTROL_RST  = 8'h00;
  localparam logic [7:0]  LIMIT_RST    = 8'h00;
  localparam logic [4:0]  SELECT_RST   = 5'h00;
  localparam logic [7:0]  READ_ZERO    = 8'h00;
  localparam logic [2:0]  SELECT_PAD   = 3'h0;

  localparam int unsigned SEL_W        = 5;
  localparam int unsigned SRC_N        = 32;
  localparam int unsigned PRE_W        = 7;
  localparam int unsigned SYNC_STAGES  = 2;

  // ---------------------------------------------------------------
  // mode codes with their own behaviour
  // ---------------------------------------------------------------
  localparam logic [4:0]  MODE_LEVEL_LOW  = 5'h16;
  localparam logic [4:0]  MODE_LEVEL_HIGH = 5'h17;

  localparam logic [7:0]  COUNT_ONE    = 8'h01;
  localparam logic [7:0]  PRE_ONE      = 8'h01;
  localparam logic [3:0]  POST_ONE     = 4'h1;
  localparam logic [3:0]  POST_ZERO    = 4'h0;
  localparam logic [1:0]  EN_SYNC_ZERO = 2'h0;

  // ---------------------------------------------------------------
  // register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       on;
    logic [2:0] clock_divide_select;
    logic [3:0] output_divide_select;
  } control_t;

  typedef struct packed {
    logic       divider_sync_enable;
    logic       clock_edge_select;
    logic       enable_sync_enable;
    logic [4:0] mode;
  } limit_t;

  typedef enum logic [2:0] {
    ST_OFF  = 3'h1,
    ST_RUN  = 3'h2,
    ST_HELD = 3'h4
  } run_state_t;

endpackage : timer8_pkg

// [src/timer8_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module timer8_sync #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // ---------------------------------------------------------------
  // two-stage synchroniser per bit
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        meta_d[g] = async_i[g];
        sync_d[g] = meta_q[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : timer8_sync

`default_nettype wire

// [src/timer8_hw_limit_control.sv]
// Function
// - enable low resets prescaler, postscaler and state machines
// - prescaler divides by two to the code
// - postscaler divides match events by code+1
// - hardware clears enable in one-shot modes
// - divider sync bit registers prescaler output
// - synchronised prescaler stops during sleep
// - edge bit picks falling or rising edge
// - enable sync adds two input clocks
// - enable gates counting, stop holds count
// - match clears counter on next tick
// - five-bit mode field selects operation
// - five-bit field selects input clock
// - five-bit field selects reset source
// - counter restarts at zero after period
// - level one-shot holds reset, match clears enable
`timescale 1ns/100ps
`default_nettype none

module timer8_hw_limit_control (
  input  wire logic                                       clk_sys_i,
  input  wire logic                                       rst_b_i,
  input  wire logic [timer8_pkg::ADDR_W-1:0]              addr_i,
  input  wire logic [timer8_pkg::DATA_W-1:0]              wr_data_i,
  input  wire logic                                       wr_i,
  input  wire logic                                       rd_i,
  input  wire logic [timer8_pkg::SRC_N-1:0]               clk_src_i,
  input  wire logic [timer8_pkg::SRC_N-1:0]               rst_src_i,
  input  wire logic                                       sleep_i,
  output logic      [timer8_pkg::DATA_W-1:0]              rd_data_o,
  output logic                                            match_o,
  output logic                                            post_out_o,
  output logic                                            running_o
);

  import timer8_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  control_t         control_q;
  control_t         control_d;
  limit_t           limit_q;
  limit_t           limit_d;
  logic [SEL_W-1:0] clk_sel_q;
  logic [SEL_W-1:0] clk_sel_d;
  logic [SEL_W-1:0] rst_sel_q;
  logic [SEL_W-1:0] rst_sel_d;
  logic [7:0]       period_q;
  logic [7:0]       period_d;
  logic [7:0]       count_q;
  logic [7:0]       count_d;
  logic [PRE_W-1:0] pre_cnt_q;
  logic [PRE_W-1:0] pre_cnt_d;
  logic [3:0]       post_cnt_q;
  logic [3:0]       post_cnt_d;
  logic [1:0]       en_sync_q;
  logic [1:0]       en_sync_d;
  logic             clk_prev_q;
  logic             clk_prev_d;
  logic             pre_tick_q;
  logic             pre_tick_d;
  run_state_t       state_q;
  run_state_t       state_d;
  logic [7:0]       rd_data_q;
  logic [7:0]       rd_data_d;
  logic             match_q;
  logic             match_d;
  logic             post_out_q;
  logic             post_out_d;
  logic             running_q;
  logic             running_d;

  logic [SRC_N-1:0] clk_sync;
  logic [SRC_N-1:0] rst_sync;
  logic             clk_cur;
  logic             in_tick;
  logic             gate_en;
  logic             level_mode;
  logic             ext_active;
  logic [PRE_W-1:0] pre_limit;
  logic             pre_hit;
  logic             tmr_tick;
  logic             period_hit;
  logic             wr_control;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  timer8_sync #(.WIDTH(SRC_N)) u_clk_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (clk_src_i),
    .sync_o    (clk_sync)
  );

  timer8_sync #(.WIDTH(SRC_N)) u_rst_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (rst_src_i),
    .sync_o    (rst_sync)
  );

  // ---------------------------------------------------------------
  // clock selection, edge and enable gating
  // ---------------------------------------------------------------
  always_comb begin
    clk_cur    = clk_sync[clk_sel_q];
    // chosen edge of the selected input clock
    in_tick    = limit_q.clock_edge_select ? (~clk_cur & clk_prev_q)
                                           : (clk_cur & ~clk_prev_q);
    gate_en    = limit_q.enable_sync_enable ? en_sync_q[1]
                                            : control_q.on;
    level_mode = (limit_q.mode == MODE_LEVEL_LOW) ||
                 (limit_q.mode == MODE_LEVEL_HIGH);
    ext_active = (limit_q.mode == MODE_LEVEL_LOW) ? ~rst_sync[rst_sel_q]
                                                  : rst_sync[rst_sel_q];
    pre_limit  = PRE_W'((PRE_ONE << control_q.clock_divide_select) - PRE_ONE);
    pre_hit    = in_tick && (pre_cnt_q == pre_limit) && (state_q == ST_RUN);
    // synchronised output is one cycle late and blocked in sleep
    tmr_tick   = limit_q.divider_sync_enable ? (pre_tick_q & ~sleep_i)
                                             : pre_hit;
    period_hit = tmr_tick && (state_q == ST_RUN) && (count_q == period_q);
    wr_control = wr_i && (addr_i == ADDR_CONTROL);
  end

  // ---------------------------------------------------------------
  // run state
  // ---------------------------------------------------------------
  always_comb begin
    clk_prev_d = clk_cur;
    en_sync_d  = en_sync_q;
    if (!control_q.on) begin
      en_sync_d = EN_SYNC_ZERO;
    end else if (in_tick) begin
      en_sync_d = {en_sync_q[0], control_q.on};
    end
    if (!gate_en) begin
      state_d = ST_OFF;
    end else if (level_mode && ext_active) begin
      state_d = ST_HELD;
    end else begin
      state_d = ST_RUN;
    end
    // registered copy of the run decode keeps the output on a flop
    running_d  = (state_d == ST_RUN);
  end

  // ---------------------------------------------------------------
  // prescaler, counter and postscaler
  // ---------------------------------------------------------------
  always_comb begin
    pre_cnt_d  = pre_cnt_q;
    pre_tick_d = pre_hit && ~sleep_i;
    post_cnt_d = post_cnt_q;
    count_d    = count_q;
    match_d    = 1'b0;
    post_out_d = 1'b0;
    case (state_q)
      ST_OFF: begin
        pre_cnt_d  = '0;
        pre_tick_d = 1'b0;
        post_cnt_d = POST_ZERO;
      end
      ST_HELD: begin
        pre_cnt_d  = '0;
        pre_tick_d = 1'b0;
        count_d    = COUNTER_RST;
      end
      ST_RUN: begin
        if (limit_q.divider_sync_enable && sleep_i) begin
          pre_cnt_d = pre_cnt_q;
        end else if (pre_hit) begin
          pre_cnt_d = '0;
        end else if (in_tick) begin
          pre_cnt_d = PRE_W'(pre_cnt_q + PRE_W'(1));
        end
        if (period_hit) begin
          count_d = COUNTER_RST;
          match_d = 1'b1;
          if (post_cnt_q == control_q.output_divide_select) begin
            post_cnt_d = POST_ZERO;
            post_out_d = 1'b1;
          end else begin
            post_cnt_d = 4'(post_cnt_q + POST_ONE);
          end
        end else if (tmr_tick) begin
          count_d = 8'(count_q + COUNT_ONE);
        end
      end
      default: begin
        pre_cnt_d = '0;
      end
    endcase
    if (wr_i && (addr_i == ADDR_COUNTER)) begin
      count_d = wr_data_i;
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_comb begin
    control_d = control_q;
    limit_d   = limit_q;
    period_d  = period_q;
    clk_sel_d = clk_sel_q;
    rst_sel_d = rst_sel_q;
    // hardware clear first so a software write in the same cycle wins
    if (level_mode && period_hit) begin
      control_d.on = 1'b0;
    end
    if (wr_control) begin
      control_d = control_t'(wr_data_i);
    end else if (wr_i && (addr_i == ADDR_LIMIT)) begin
      limit_d = limit_t'(wr_data_i);
    end else if (wr_i && (addr_i == ADDR_PERIOD)) begin
      period_d = wr_data_i;
    end else if (wr_i && (addr_i == ADDR_CLOCK_SELECT)) begin
      clk_sel_d = wr_data_i[SEL_W-1:0];
    end else if (wr_i && (addr_i == ADDR_RESET_SELECT)) begin
      rst_sel_d = wr_data_i[SEL_W-1:0];
    end
  end

  always_comb begin
    rd_data_d = READ_ZERO;
    if (!rd_i) begin
      rd_data_d = READ_ZERO;
    end else if (addr_i == ADDR_COUNTER) begin
      rd_data_d = count_q;
    end else if (addr_i == ADDR_PERIOD) begin
      rd_data_d = period_q;
    end else if (addr_i == ADDR_CONTROL) begin
      rd_data_d = control_q;
    end else if (addr_i == ADDR_LIMIT) begin
      rd_data_d = limit_q;
    end else if (addr_i == ADDR_CLOCK_SELECT) begin
      rd_data_d = {SELECT_PAD, clk_sel_q};
    end else if (addr_i == ADDR_RESET_SELECT) begin
      rd_data_d = {SELECT_PAD, rst_sel_q};
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      control_q  <= control_t'(CONTROL_RST);
      limit_q    <= limit_t'(LIMIT_RST);
      period_q   <= PERIOD_RST;
      clk_sel_q  <= SELECT_RST;
      rst_sel_q  <= SELECT_RST;
      count_q    <= COUNTER_RST;
      pre_cnt_q  <= '0;
      post_cnt_q <= POST_ZERO;
      en_sync_q  <= EN_SYNC_ZERO;
      clk_prev_q <= 1'b0;
      pre_tick_q <= 1'b0;
      state_q    <= ST_OFF;
      rd_data_q  <= READ_ZERO;
      match_q    <= 1'b0;
      post_out_q <= 1'b0;
      running_q  <= 1'b0;
    end else begin
      control_q  <= control_d;
      limit_q    <= limit_d;
      period_q   <= period_d;
      clk_sel_q  <= clk_sel_d;
      rst_sel_q  <= rst_sel_d;
      count_q    <= count_d;
      pre_cnt_q  <= pre_cnt_d;
      post_cnt_q <= post_cnt_d;
      en_sync_q  <= en_sync_d;
      clk_prev_q <= clk_prev_d;
      pre_tick_q <= pre_tick_d;
      state_q    <= state_d;
      rd_data_q  <= rd_data_d;
      match_q    <= match_d;
      post_out_q <= post_out_d;
      running_q  <= running_d;
    end
  end

  assign rd_data_o  = rd_data_q;
  assign match_o    = match_q;
  assign post_out_o = post_out_q;
  assign running_o  = running_q;

endmodule : timer8_hw_limit_control

`default_nettype wire

// [verification/timer8_hw_limit_control_monitor.sv]
`timescale 1ns/100ps
`default_nettype none

module timer8_hw_limit_control_monitor
  import timer8_pkg::*;
(
  input wire logic                                  clk_sys_i,
  input wire logic                                  rst_b_i,
  input wire logic [timer8_pkg::ADDR_W-1:0]         addr_i,
  input wire logic [timer8_pkg::DATA_W-1:0]         wr_data_i,
  input wire logic                                  wr_i,
  input wire logic                                  rd_i,
  input wire logic                                  sleep_i,
  input wire logic [timer8_pkg::DATA_W-1:0]         rd_data_o,
  input wire logic                                  match_o,
  input wire logic                                  post_out_o,
  input wire logic                                  running_o
);
  // ---------------------------------------------------------------
  // shadow of the limit register
  // ---------------------------------------------------------------
  limit_t lim_q;
  limit_t lim_d;
  logic   lvl;
  logic   on_q;
  logic   on_d;

  // software view of the enable bit; hardware clears are not seen here
  always_comb begin
    lim_d = lim_q;
    on_d  = on_q;
    if (wr_i && addr_i == ADDR_LIMIT) begin
      lim_d = limit_t'(wr_data_i);
    end
    if (wr_i && addr_i == ADDR_CONTROL) begin
      on_d = wr_data_i[7];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      lim_q <= limit_t'(LIMIT_RST);
      on_q  <= 1'b0;
    end else begin
      lim_q <= lim_d;
      on_q  <= on_d;
    end
  end

  assign lvl = (lim_q.mode == MODE_LEVEL_LOW) || (lim_q.mode == MODE_LEVEL_HIGH);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence on_wr_s;
    wr_i && addr_i == ADDR_CONTROL && wr_data_i[7];
  endsequence

  sequence off_wr_s;
    wr_i && addr_i == ADDR_CONTROL && !wr_data_i[7];
  endsequence

  reset_quiet_a: assert property ($rose(rst_b_i) |-> !running_o && !match_o &&
    !post_out_o && rd_data_o == 8'h00) else $error("outputs not quiet after reset");
  off_stops_a: assert property (off_wr_s |-> ##[2:3] !running_o)
    else $error("timer still running after off");
  on_starts_a: assert property (on_wr_s ##0 (!lim_q.enable_sync_enable && !lvl)
    |-> ##[1:2] running_o) else $error("timer did not start");
  sync_delay_a: assert property (on_wr_s ##0 (lim_q.enable_sync_enable && !on_q &&
    !$past(on_q)) |=> !running_o [*2]) else $error("synchronised start too early");
  stopped_quiet_a: assert property (!running_o && !$past(running_o) |-> !match_o)
    else $error("match while stopped");
  sleep_hold_a: assert property ((lim_q.divider_sync_enable && sleep_i)[*4] |-> !match_o)
    else $error("match during sleep");
  post_follows_a: assert property (post_out_o |-> match_o || $past(match_o) ||
    $past(match_o, 2)) else $error("postscaler pulse without match");
  pad_zero_a: assert property (rd_i && (addr_i == ADDR_CLOCK_SELECT ||
    addr_i == ADDR_RESET_SELECT) |=> rd_data_o[7:5] == 3'h0) else $error("select pad set");
  rd_idle_a: assert property ((!rd_i || addr_i == 14'h0000) |=> rd_data_o == 8'h00)
    else $error("read data not zero");

endmodule : timer8_hw_limit_control_monitor

bind timer8_hw_limit_control timer8_hw_limit_control_monitor mon (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_i(wr_i), .rd_i(rd_i), .sleep_i(sleep_i), .rd_data_o(rd_data_o), .match_o(match_o),
  .post_out_o(post_out_o), .running_o(running_o));

`default_nettype wire

// [verification/timer8_hw_limit_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none

module timer8_hw_limit_control_bench;
  import timer8_pkg::*;

  logic        clk_sys_i;
  logic        rst_b_i;
  logic [13:0] addr_i;
  logic [7:0]  wr_data_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] clk_src_i;
  logic [31:0] rst_src_i;
  logic        sleep_i;
  logic [7:0]  rd_data_o;
  logic        match_o;
  logic        post_out_o;
  logic        running_o;
  logic [7:0]  nm;
  logic [7:0]  np;
  int          errors;
  int          comparisons;
  int          sel;

  timer8_hw_limit_control uut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .clk_src_i(clk_src_i), .rst_src_i(rst_src_i),
    .sleep_i(sleep_i), .rd_data_o(rd_data_o), .match_o(match_o),
    .post_out_o(post_out_o), .running_o(running_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    if (match_o === 1'b1) nm = nm + 8'h01;
    if (post_out_o === 1'b1) np = np + 8'h01;
  end

  // ---------------------------------------------------------------
  // bus, stimulus and compare tasks
  // ---------------------------------------------------------------
  task end_of_test;
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [13:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(rd_data_o, exp);
    @(posedge clk_sys_i);
  endtask : rd

  task edges(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk_sys_i);
      clk_src_i[sel] <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      clk_src_i[sel] <= 1'b0;
    end
    repeat (6) @(posedge clk_sys_i);
  endtask : edges

  task cfg(input logic [7:0] ctl, input logic [7:0] lim, input logic [7:0] per);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_LIMIT, lim);
    wr(ADDR_PERIOD, per);
    wr(ADDR_COUNTER, 8'h00);
    nm = 8'h00;
    np = 8'h00;
    wr(ADDR_CONTROL, ctl);
  endtask : cfg

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    rd(ADDR_COUNTER, COUNTER_RST);
    rd(ADDR_PERIOD, PERIOD_RST);
    rd(ADDR_CONTROL, CONTROL_RST);
    rd(ADDR_CLOCK_SELECT, 8'h00);
    rd(ADDR_RESET_SELECT, 8'h00);
    for (int m = 0; m < 32; m++) begin
      wr(ADDR_LIMIT, {3'h5, m[4:0]});
      rd(ADDR_LIMIT, {3'h5, m[4:0]});
    end
    wr(ADDR_CLOCK_SELECT, 8'hff);
    rd(ADDR_CLOCK_SELECT, 8'h1f);
    wr(ADDR_RESET_SELECT, 8'he3);
    rd(ADDR_RESET_SELECT, 8'h03);
    wr(14'h0000, 8'h55);
    rd(14'h0000, 8'h00);
    wr(ADDR_CLOCK_SELECT, 8'h05);
  endtask : t_regs

  task t_prescale;
    for (int ps = 0; ps < 8; ps++) begin
      cfg({1'b1, ps[2:0], 4'h0}, 8'h00, 8'h01);
      edges(2 << ps);
      chk(nm, 8'h01);
      rd(ADDR_COUNTER, 8'h00);
    end
  endtask : t_prescale

  task t_post;
    for (int c = 0; c < 16; c++) begin
      cfg({4'h8, c[3:0]}, 8'h00, 8'h00);
      edges(2 * (c + 1));
      chk(np, 8'h02);
      chk(nm, 8'(2 * (c + 1)));
    end
  endtask : t_post

  task t_stop;
    cfg(8'h80, 8'h00, 8'hff);
    edges(3);
    wr(ADDR_CONTROL, 8'h00);
    edges(2);
    rd(ADDR_COUNTER, 8'h03);
    chk({7'h0, running_o}, 8'h00);
  endtask : t_stop

  task t_edge;
    cfg(8'h80, 8'h40, 8'hff);
    repeat (3) @(posedge clk_sys_i);
    clk_src_i[sel] <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rd(ADDR_COUNTER, 8'h00);
    clk_src_i[sel] <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rd(ADDR_COUNTER, 8'h01);
  endtask : t_edge

  task t_esync;
    cfg(8'h80, 8'h20, 8'hff);
    repeat (8) @(posedge clk_sys_i);
    chk({7'h0, running_o}, 8'h00);
    edges(2);
    chk({7'h0, running_o}, 8'h01);
  endtask : t_esync

  task t_sleep;
    cfg(8'h80, 8'h80, 8'hff);
    sleep_i <= 1'b1;
    edges(4);
    rd(ADDR_COUNTER, 8'h00);
    sleep_i <= 1'b0;
    edges(4);
    rd(ADDR_COUNTER, 8'h04);
  endtask : t_sleep

  task t_level;
    for (int i = 0; i < 2; i++) begin
      rst_src_i[3] <= i[0];
      cfg(8'h80, {3'h0, MODE_LEVEL_LOW + 5'(i)}, 8'h01);
      edges(3);
      rd(ADDR_COUNTER, 8'h00);
      rst_src_i[3] <= ~i[0];
      edges(2);
      chk(nm, 8'h01);
      rd(ADDR_CONTROL, 8'h00);
      edges(2);
      chk(nm, 8'h01);
    end
  endtask : t_level

  initial begin
    rst_b_i = 1'b0;
    addr_i = 14'h0000;
    wr_data_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    clk_src_i = 32'h0000_0000;
    rst_src_i = 32'h0000_0000;
    sleep_i = 1'b0;
    nm = 8'h00;
    np = 8'h00;
    errors = 0;
    comparisons = 0;
    sel = 5;
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_prescale();
    t_post();
    t_stop();
    t_edge();
    t_esync();
    t_sleep();
    t_level();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    end_of_test();
  end

endmodule : timer8_hw_limit_control_bench

`default_nettype wire
